// >>> design/psw_cfg_mem.sv
`timescale 1ns/100ps
package psw_pkg;
	localparam int          PSW_NUM_SW    = 16;
	localparam int          PSW_IDX_W     = 4;
	localparam int          PSW_OUT_W     = 5;
	localparam int          PSW_NUM_OUT   = 32;
	localparam int          PSW_UPOS_W    = 32;
	localparam int          PSW_UNIT_W    = 16;
	localparam int          PSW_PROD_W    = 64;
	localparam logic [4:0]  PSW_OUT_MIN   = 5'h08;
	localparam int          PSW_EDGES_PPR = 4;
	localparam logic [15:0] PSW_EN_RST    = 16'h0000;
	localparam logic [31:0] PSW_OUT_RST   = 32'h0000_0000;
	// Field positions of one stored switch word, counted from bit 0.
	localparam int          PSW_F_OFF     = 0;
	localparam int          PSW_F_ON      = PSW_F_OFF + PSW_UPOS_W;
	localparam int          PSW_F_LVL     = PSW_F_ON + PSW_UPOS_W;
	localparam int          PSW_F_OUT     = PSW_F_LVL + 1;
	localparam int          PSW_F_AXIS    = PSW_F_OUT + PSW_OUT_W;
endpackage

module psw_cfg_mem #(
	parameter int WIDTH = 72,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             ce_i,
	// Write port
	input  wire logic             we_i,
	input  wire logic [AW-1:0]    waddr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	// Read port, data one cycle after the address
	input  wire logic [AW-1:0]    raddr_i,
	output logic      [WIDTH-1:0] rdata_o
);
	logic [WIDTH-1:0] mem_q [DEPTH];

	// The array carries no reset so it can map onto plain storage cells.
	always_ff @(posedge clk_i) begin
		if (ce_i && we_i) begin
			mem_q[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= '0;
		end else if (ce_i) begin
			rdata_o <= mem_q[raddr_i];
		end
	end
endmodule // psw_cfg_mem

// >>> design/psw_top.sv
// Notes on behaviour
// - Sixteen switches, each with own axis, on and off position and output.
// - Enabled switch drives output on at on position, off at off position.
// - Every switch is evaluated once per servo tick, two cycles each, so outputs lag the tick by up to 32 cycles.
// - Disabling leaves the output as it is until a general output write.
// - Stored level is driven while the position is inside the active span.
// - Positions kept in user units, scaled by axis units factor for compare.
// - Encoder counting takes four edges per pulse.
// - Switching is periodic per servo tick, not edge-exact.
`timescale 1ns/100ps
module psw_top
	import psw_pkg::*;
#(
	parameter int NUM_AXES = 2,
	parameter int AXIS_W   = 2,
	parameter int POS_W    = 32
) (
	// Clock, reset, enable
	input  wire logic                         MCLK_I,
	input  wire logic                         RST_B_I,
	input  wire logic                         CE_I,
	// Servo cycle reference, one-cycle pulse
	input  wire logic                         SERVO_TICK_I,
	// Encoder pins per axis
	input  wire logic [NUM_AXES-1:0]          ENC_A_I,
	input  wire logic [NUM_AXES-1:0]          ENC_B_I,
	// Units conversion factor per axis, counts per user unit
	input  wire logic [NUM_AXES*PSW_UNIT_W-1:0] UNITS_I,
	// Switch configuration
	input  wire logic                         CFG_WR_I,
	input  wire logic                         CFG_FULL_I,
	input  wire logic [PSW_IDX_W-1:0]         CFG_IDX_I,
	input  wire logic                         CFG_EN_I,
	input  wire logic [AXIS_W-1:0]            CFG_AXIS_I,
	input  wire logic [PSW_OUT_W-1:0]         CFG_OUT_I,
	input  wire logic                         CFG_LVL_I,
	input  wire logic [PSW_UPOS_W-1:0]        CFG_ON_I,
	input  wire logic [PSW_UPOS_W-1:0]        CFG_OFF_I,
	// General output write
	input  wire logic                         GENERAL_OUTPUT_WRITE_I,
	input  wire logic [PSW_OUT_W-1:0]         GOW_NUM_I,
	input  wire logic                         GOW_VAL_I,
	// Status and outputs
	output logic      [PSW_NUM_OUT-1:0]       OUT_O,
	output logic      [PSW_NUM_SW-1:0]        SW_EN_O,
	output logic                              BUSY_O
);
	localparam int MEM_W = AXIS_W + PSW_F_AXIS;

	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EVAL} psw_st_t;

	typedef struct packed {
		psw_st_t                          st;
		logic [PSW_IDX_W-1:0]             idx;
		logic [PSW_NUM_SW-1:0]            en;
		logic [PSW_NUM_OUT-1:0]           out;
		logic [NUM_AXES-1:0]              a1;
		logic [NUM_AXES-1:0]              a2;
		logic [NUM_AXES-1:0]              a3;
		logic [NUM_AXES-1:0]              b1;
		logic [NUM_AXES-1:0]              b2;
		logic [NUM_AXES-1:0]              b3;
		logic [NUM_AXES-1:0][POS_W-1:0]   cnt;
		logic [NUM_AXES-1:0][POS_W-1:0]   smp;
		logic                             busy;
	} psw_state_t;

	psw_state_t       s_q;
	psw_state_t       s_d;
	logic [MEM_W-1:0] rd_data;
	logic [MEM_W-1:0] wr_data;

	// One step of a x4 quadrature count: every edge of A or B moves by one.
	function automatic logic signed [1:0] quad_step(input logic pa, input logic pb,
		input logic ca, input logic cb);
		logic [3:0] t;
		t = {pa, pb, ca, cb};
		unique case (t)
			4'h1, 4'h7, 4'hE, 4'h8: quad_step = 2'sd1;
			4'h2, 4'hB, 4'hD, 4'h4: quad_step = -2'sd1;
			default:                quad_step = 2'sd0;
		endcase
	endfunction

	// User units to encoder counts; wide enough that no product overflows.
	function automatic logic signed [PSW_PROD_W-1:0] to_counts(
		input logic [PSW_UPOS_W-1:0] u, input logic [PSW_UNIT_W-1:0] f);
		logic signed [PSW_PROD_W-1:0] a;
		logic signed [PSW_PROD_W-1:0] b;
		a = PSW_PROD_W'($signed(u));
		b = PSW_PROD_W'($signed({1'b0, f}));
		to_counts = a * b;
	endfunction

	// An axis number past the last fitted axis leaves the switch inert.
	function automatic logic axis_ok(input logic [AXIS_W-1:0] a);
		axis_ok = (int'(a) < NUM_AXES);
	endfunction

	assign wr_data = {CFG_AXIS_I, CFG_OUT_I, CFG_LVL_I, CFG_ON_I, CFG_OFF_I};

	psw_cfg_mem #(
		.WIDTH (MEM_W),
		.DEPTH (PSW_NUM_SW),
		.AW    (PSW_IDX_W)
	) u_mem (
		.clk_i   (MCLK_I),
		.rst_b_i (RST_B_I),
		.ce_i    (CE_I),
		.we_i    (CFG_WR_I && CFG_FULL_I),
		.waddr_i (CFG_IDX_I),
		.wdata_i (wr_data),
		.raddr_i (s_q.idx),
		.rdata_o (rd_data)
	);

	always_comb begin
		logic [AXIS_W-1:0]            ax;
		logic [PSW_OUT_W-1:0]         onum;
		logic                         lvl;
		logic signed [PSW_PROD_W-1:0] pos;
		logic signed [PSW_PROD_W-1:0] onc;
		logic signed [PSW_PROD_W-1:0] offc;
		logic [PSW_UNIT_W-1:0]        units;
		logic                         active;
		ax     = rd_data[PSW_F_AXIS +: AXIS_W];
		onum   = rd_data[PSW_F_OUT +: PSW_OUT_W];
		lvl    = rd_data[PSW_F_LVL];
		pos    = '0;
		units  = '0;
		onc    = '0;
		offc   = '0;
		active = 1'b0;
		s_d    = s_q;

		// Encoder pins pass two flops; the third keeps the previous level.
		// The count wraps silently, so very long travel in one direction aliases.
		s_d.a1 = ENC_A_I;
		s_d.a2 = s_q.a1;
		s_d.a3 = s_q.a2;
		s_d.b1 = ENC_B_I;
		s_d.b2 = s_q.b1;
		s_d.b3 = s_q.b2;
		for (int i = 0; i < NUM_AXES; i++) begin
			s_d.cnt[i] = s_q.cnt[i] + POS_W'(quad_step(s_q.a3[i], s_q.b3[i],
				s_q.a2[i], s_q.b2[i]));
		end

		if (CFG_WR_I) begin
			if (CFG_FULL_I) begin
				s_d.en[CFG_IDX_I] = CFG_EN_I;
			end else if (!CFG_EN_I) begin
				s_d.en[CFG_IDX_I] = 1'b0;
			end
		end

		unique case (s_q.st)
			ST_IDLE: begin
				if (SERVO_TICK_I) begin
					s_d.smp = s_q.cnt;
					s_d.idx = '0;
					s_d.st  = ST_READ;
				end
			end
			ST_READ: begin
				// The memory needs this cycle to present the word, so two cycles per switch.
				s_d.st = ST_EVAL;
			end
			ST_EVAL: begin
				// Units are read live, so changing them mid-scan splits the bank
				// between the old and the new scaling.
				if (axis_ok(ax)) begin
					units = UNITS_I[int'(ax)*PSW_UNIT_W +: PSW_UNIT_W];
					pos   = PSW_PROD_W'($signed(s_q.smp[ax]));
				end
				onc  = to_counts(rd_data[PSW_F_ON +: PSW_UPOS_W], units);
				offc = to_counts(rd_data[PSW_F_OFF +: PSW_UPOS_W], units);
				if (onc < offc) begin
					active = (pos >= onc) && (pos < offc);
				end else begin
					// A span with on above off wraps through the axis origin.
					active = (pos >= onc) || (pos < offc);
				end
				// A disabled switch never touches its output, so it holds.
				if (s_q.en[s_q.idx] && onc != offc && onum >= PSW_OUT_MIN &&
					axis_ok(ax)) begin
					s_d.out[onum] = active ? lvl : ~lvl;
				end
				s_d.idx = s_q.idx + 1'b1;
				s_d.st  = (s_q.idx == PSW_IDX_W'(PSW_NUM_SW - 1)) ? ST_IDLE : ST_READ;
			end
		endcase

		// A software write lands after the scan's result for the same bit.
		if (GENERAL_OUTPUT_WRITE_I && GOW_NUM_I >= PSW_OUT_MIN) begin
			s_d.out[GOW_NUM_I] = GOW_VAL_I;
		end

		// Busy has a flop of its own so the pin carries no decode glitches.
		s_d.busy = (s_d.st != ST_IDLE);
	end

	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			s_q     <= '0;
			s_q.st  <= ST_IDLE;
			s_q.en  <= PSW_EN_RST;
			s_q.out <= PSW_OUT_RST;
		end else if (CE_I) begin
			s_q <= s_d;
		end
	end

	assign OUT_O   = s_q.out;
	assign SW_EN_O = s_q.en;
	assign BUSY_O  = s_q.busy;
endmodule // psw_top

// >>> verification/psw_enc_model.sv
`timescale 1ns/100ps
module psw_enc_model (
	// Clock and step requests per axis
	input  wire logic       clk_i,
	input  wire logic [1:0] up_i,
	input  wire logic [1:0] dn_i,
	// Quadrature pins
	output logic      [1:0] a_o,
	output logic      [1:0] b_o
);
	logic [1:0] ph_q [2] = '{2'h0, 2'h0};
	// One step is one counted edge, so a full pulse is four steps.
	always_ff @(posedge clk_i) begin
		for (int k = 0; k < 2; k++)
			ph_q[k] <= ph_q[k] + 2'(up_i[k]) - 2'(dn_i[k]);
	end
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			a_o[k] = ph_q[k][1];
			b_o[k] = ^ph_q[k];
		end
	end
endmodule // psw_enc_model

// >>> verification/psw_top_monitor.sv
`timescale 1ns/100ps
module psw_top_monitor
	import psw_pkg::*;
(
	input wire logic                   MCLK_I,
	input wire logic                   RST_B_I,
	input wire logic                   CE_I,
	input wire logic                   SERVO_TICK_I,
	input wire logic                   CFG_WR_I,
	input wire logic                   CFG_FULL_I,
	input wire logic [PSW_IDX_W-1:0]   CFG_IDX_I,
	input wire logic                   CFG_EN_I,
	input wire logic                   GENERAL_OUTPUT_WRITE_I,
	input wire logic [PSW_OUT_W-1:0]   GOW_NUM_I,
	input wire logic                   GOW_VAL_I,
	input wire logic [PSW_NUM_OUT-1:0] OUT_O,
	input wire logic [PSW_NUM_SW-1:0]  SW_EN_O,
	input wire logic                   BUSY_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_B_I);
	// Counts enabled busy cycles so a scan of the wrong length is caught.
	logic [5:0] bc_q;
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			bc_q <= '0;
		else if (!BUSY_O)
			bc_q <= '0;
		else if (CE_I)
			bc_q <= bc_q + 6'h01;
	end
	scan_start_a: assert property (CE_I && SERVO_TICK_I && !BUSY_O |=> BUSY_O)
		else $error("scan did not start on tick");
	scan_len_a: assert property ($fell(BUSY_O) |-> bc_q == 6'h20)
		else $error("scan length wrong");
	low_outs_a: assert property (OUT_O[7:0] == 8'h00)
		else $error("low output driven");
	idle_hold_a: assert property (!BUSY_O && !GENERAL_OUTPUT_WRITE_I |=> $stable(OUT_O))
		else $error("output moved outside scan");
	gen_write_a: assert property (CE_I && GENERAL_OUTPUT_WRITE_I && GOW_NUM_I >= PSW_OUT_MIN
		|=> OUT_O[$past(GOW_NUM_I)] == $past(GOW_VAL_I))
		else $error("general write lost");
	sw_on_a: assert property (CE_I && CFG_WR_I && CFG_FULL_I && CFG_EN_I
		|=> SW_EN_O[$past(CFG_IDX_I)])
		else $error("switch not enabled");
	sw_off_a: assert property (CE_I && CFG_WR_I && !CFG_EN_I |=> !SW_EN_O[$past(CFG_IDX_I)])
		else $error("switch not disabled");
	short_ign_a: assert property (CE_I && CFG_WR_I && !CFG_FULL_I && CFG_EN_I
		|=> $stable(SW_EN_O))
		else $error("short form enabled a switch");
endmodule // psw_top_monitor

// >>> verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic        clk = 0, rst_b = 0, ce = 1, tick = 0, wr = 0, full = 0, en = 0, lvl = 0;
	logic        gw = 0, gv = 0;
	logic [1:0]  up = 0, dn = 0, ax = 0, ea, eb;
	logic [3:0]  idx = 0;
	logic [4:0]  onum = 0, gn = 0;
	logic [15:0] u = 16'h0001, sw_en;
	logic [31:0] on_p = 0, off_p = 0, out;
	logic        busy;
	int          error_cnt = 0, n_tests = 0, cyc = 0, pos = 0;
	initial forever #4 clk = ~clk;
	psw_enc_model psw_enc_model_inst (.clk_i(clk), .up_i(up), .dn_i(dn), .a_o(ea), .b_o(eb));
	psw_top psw_top_inst (.MCLK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .SERVO_TICK_I(tick),
		.ENC_A_I(ea), .ENC_B_I(eb), .UNITS_I({u, u}), .CFG_WR_I(wr), .CFG_FULL_I(full),
		.CFG_IDX_I(idx), .CFG_EN_I(en), .CFG_AXIS_I(ax), .CFG_OUT_I(onum), .CFG_LVL_I(lvl),
		.CFG_ON_I(on_p), .CFG_OFF_I(off_p), .GENERAL_OUTPUT_WRITE_I(gw), .GOW_NUM_I(gn),
		.GOW_VAL_I(gv), .OUT_O(out), .SW_EN_O(sw_en), .BUSY_O(busy));
	function automatic bit act(int p, int a, int b);
		return (a < b) ? (p >= a && p < b) : (p >= a || p < b);
	endfunction
	task automatic chk(logic g, logic e, string m);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	task automatic cfg(bit f, bit e, int i, int o, bit l, int a, int b);
		{full, en, lvl, idx, onum, on_p, off_p} = {f, e, l, 4'(i), 5'(o), a, b};
		wr = 1;
		@(negedge clk);
		wr = 0;
		@(negedge clk);
	endtask
	task automatic mv(int n);
		repeat ((n < 0) ? -n : n) begin
			{up[0], dn[0]} = (n > 0) ? 2'b10 : 2'b01;
			@(negedge clk);
			{up[0], dn[0]} = 2'b00;
			repeat (3) @(negedge clk);
		end
		pos += n;
		repeat (4) @(negedge clk);
	endtask
	// A second tick in mid-scan must be dropped, and an enable pause stretches the scan.
	task automatic scan();
		tick = 1;
		@(negedge clk);
		tick = 0;
		repeat (5) @(negedge clk);
		tick = 1;
		@(negedge clk);
		tick = 0;
		ce = 0;
		repeat (3) @(negedge clk);
		ce = 1;
		repeat (25) @(negedge clk);
		chk(busy, 1, "frozen scan");
		@(negedge clk);
		chk(busy, 0, "scan end");
		repeat (2) @(negedge clk);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	initial begin
		void'($urandom(32'h090f_09ca));
		u = 16'($urandom_range(4, 1));
		repeat (20) @(negedge clk);
		rst_b = 1;
		@(negedge clk);
		cfg(1, 1, 0, 11, 1, 2, 5);
		cfg(0, 1, 1, 0, 0, 0, 0);
		chk(sw_en[1], 0, "short form");
		cfg(1, 1, 1, 3, 1, 0, 99);
		cfg(1, 1, 2, 12, 0, 6, 1);
		cfg(1, 1, 15, 13, 1, 3, 3);
		chk(sw_en[15], 1, "enable");
		ax = 2'h1;
		cfg(1, 1, 3, 14, 1, 0, 2);
		ax = 2'h2;
		cfg(1, 1, 4, 15, 1, 0, 9);
		ax = 2'h0;
		$display("test config done");
		repeat (6) begin
			mv($urandom_range(8 * u) - pos);
			scan();
			chk(out[11], act(pos, 2 * u, 5 * u), "span");
			chk(out[12], !act(pos, 6 * u, u), "wrap level");
			chk(out[13], 0, "equal ends");
			chk(out[3], 0, "low output");
			chk(out[14], act(0, 0, 2 * u), "other axis");
			chk(out[15], 0, "inert axis");
		end
		$display("test scan done");
		mv(3 * u - pos);
		scan();
		cfg(0, 0, 0, 0, 0, 0, 0);
		chk(sw_en[0], 0, "disable");
		mv(7 * u - pos);
		scan();
		chk(out[11], 1, "held on");
		{gw, gn, gv} = {1'b1, 5'd11, 1'b0};
		@(negedge clk);
		gw = 0;
		@(negedge clk);
		chk(out[11], 0, "general write");
		$display("test disable done");
		tally_and_finish();
	end
endmodule // tb_top
bind psw_top psw_top_monitor psw_top_monitor_inst (.*);
